/* File: core/tws_pkg.sv */
package tws_pkg;
    localparam logic [7:0] ADR_TASK = 8'h00;
    localparam logic [7:0] ADR_EVENT = 8'h04;
    localparam logic [7:0] ADR_ENABLE = 8'h08;
    localparam logic [7:0] ADR_CONFIG = 8'h0c;
    localparam logic [7:0] ADR_LISTEN0 = 8'h10;
    localparam logic [7:0] ADR_LISTEN1 = 8'h14;
    localparam logic [7:0] ADR_FILL = 8'h18;
    localparam logic [7:0] ADR_TX_PTR = 8'h1c;
    localparam logic [7:0] ADR_TX_MAX = 8'h20;
    localparam logic [7:0] ADR_TX_AMT = 8'h24;
    localparam logic [7:0] ADR_RX_PTR = 8'h28;
    localparam logic [7:0] ADR_RX_MAX = 8'h2c;
    localparam logic [7:0] ADR_RX_AMT = 8'h30;
    localparam int TSK_PTX = 0;
    localparam int TSK_PRX = 1;
    localparam int TSK_HALT = 2;
    localparam int EV_W = 6;
    localparam int EV_STOP = 0;
    localparam int EV_RXB = 1;
    localparam int EV_TXB = 2;
    localparam int EV_READ = 3;
    localparam int EV_WRITE = 4;
    localparam int EV_ERR = 5;
    localparam int CFG_W = 2;
    localparam int CFG_A0 = 0;
    localparam int CFG_A1 = 1;
    localparam int EN_W = 4;
    localparam logic [EN_W-1:0] EN_ON = 4'h9;
    localparam logic [EN_W-1:0] EN_RST = 4'h0;
    localparam logic [CFG_W-1:0] CFG_RST = 2'h1;
    localparam logic [6:0] LISTEN_RST = 7'h00;
    localparam logic [7:0] FILL_RST = 8'h00;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic BUS_IDLE = 1'b1;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_AACK, ST_TXWAIT, ST_TXLOAD, ST_TXBITS, ST_TXACK,
        ST_TXEND, ST_RXWAIT, ST_RXBITS, ST_RXSTORE, ST_RXACK, ST_HALT
    } tws_state_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [7:0] wdata;
    } tws_dma_t;

    typedef struct packed {
        logic scl;
        logic sda;
        logic rise;
        logic fall;
        logic start;
        logic stop;
    } tws_line_t;
endpackage

/* File: core/tws_line.sv */
`timescale 1ns/100ps
`default_nettype none
module tws_line (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output var tws_pkg::tws_line_t line_o
);
    import tws_pkg::*;

    logic scl_m_reg, scl_s_reg, scl_d_reg;
    logic sda_m_reg, sda_s_reg, sda_d_reg;

    // Idle-high reset so no false start at release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_m_reg <= BUS_IDLE;
            scl_s_reg <= BUS_IDLE;
            scl_d_reg <= BUS_IDLE;
            sda_m_reg <= BUS_IDLE;
            sda_s_reg <= BUS_IDLE;
            sda_d_reg <= BUS_IDLE;
        end else begin
            scl_m_reg <= scl_i;
            scl_s_reg <= scl_m_reg;
            scl_d_reg <= scl_s_reg;
            sda_m_reg <= sda_i;
            sda_s_reg <= sda_m_reg;
            sda_d_reg <= sda_s_reg;
        end
    end

    assign line_o.scl = scl_s_reg;
    assign line_o.sda = sda_s_reg;
    assign line_o.rise = scl_s_reg & ~scl_d_reg;
    assign line_o.fall = ~scl_s_reg & scl_d_reg;
    assign line_o.start = scl_s_reg & scl_d_reg & ~sda_s_reg & sda_d_reg;
    assign line_o.stop = scl_s_reg & scl_d_reg & sda_s_reg & ~sda_d_reg;
endmodule // tws_line
`default_nettype wire

/* File: core/tws_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tws_top #(
    parameter int CNT_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output var tws_pkg::tws_dma_t mem_o,
    input wire logic [7:0] mem_rdata_i,
    input wire logic mem_ack_i,
    output logic lowpower_o
);
    import tws_pkg::*;

    tws_line_t ln;
    tws_state_t st_reg, st_next;
    logic [EN_W-1:0] en_reg;
    logic [CFG_W-1:0] cfg_reg;
    logic [6:0] adr0_reg, adr1_reg;
    logic [7:0] orc_reg, sh_reg, sh_next, dma_wd_reg;
    logic [31:0] txp_reg, rxp_reg, ptr_reg, ptr_next;
    logic [CNT_W-1:0] txm_reg, rxm_reg, max_reg, max_next;
    logic [CNT_W-1:0] txa_reg, txa_next, rxa_reg, rxa_next;
    logic [EV_W-1:0] ev_reg, ev_set, ev_clr;
    logic [3:0] cnt_reg, cnt_next;
    logic rd_reg, rd_next, nack_reg, nack_next, sda_reg, sda_next;
    logic hold_reg, prep_tx_reg, prep_rx_reg, clr_tx, clr_rx;
    logic ack_reg, dma_busy_reg, dma_go, dma_we_reg;
    logic [31:0] dma_adr, dma_adr_reg, rdat_reg, rd_mux, wmask, merged;

    tws_line u_line (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .line_o(ln)
    );

    // Wishbone decode
    wire req = cyc_i & stb_i;
    wire wr_now = req & we_i & ack_reg;
    wire rd_cap = req & ~ack_reg;
    wire enabled = (en_reg == EN_ON);
    wire hit_task = wr_now & (adr_i == ADR_TASK) & sel_i[0];
    wire task_ptx = hit_task & dat_i[TSK_PTX];
    wire task_prx = hit_task & dat_i[TSK_PRX];
    wire task_halt = hit_task & dat_i[TSK_HALT];
    assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign merged = (rd_mux & ~wmask) | (dat_i & wmask);
    assign ev_clr = (wr_now & (adr_i == ADR_EVENT)) ? merged[EV_W-1:0] : '0;

    // Prepared flags deliberately absent from readback
    assign rd_mux =
        (adr_i == ADR_EVENT) ? 32'(ev_reg) :
        (adr_i == ADR_ENABLE) ? 32'(en_reg) :
        (adr_i == ADR_CONFIG) ? 32'(cfg_reg) :
        (adr_i == ADR_LISTEN0) ? 32'(adr0_reg) :
        (adr_i == ADR_LISTEN1) ? 32'(adr1_reg) :
        (adr_i == ADR_FILL) ? 32'(orc_reg) :
        (adr_i == ADR_TX_PTR) ? txp_reg :
        (adr_i == ADR_TX_MAX) ? 32'(txm_reg) :
        (adr_i == ADR_TX_AMT) ? 32'(txa_reg) :
        (adr_i == ADR_RX_PTR) ? rxp_reg :
        (adr_i == ADR_RX_MAX) ? 32'(rxm_reg) :
        (adr_i == ADR_RX_AMT) ? 32'(rxa_reg) : 32'h0000_0000;

    assign ack_o = ack_reg;
    assign dat_o = rdat_reg;

    // Bus-side decode
    wire [6:0] adr_seen = sh_reg[7:1];
    wire addr_hit = (cfg_reg[CFG_A0] & (adr_seen == adr0_reg))
                  | (cfg_reg[CFG_A1] & (adr_seen == adr1_reg));
    wire in_xfer = (st_reg != ST_IDLE) & (st_reg != ST_HALT);
    wire restart = ln.start & ~dma_busy_reg & (st_reg != ST_HALT);
    wire stop_seen = ln.stop & in_xfer;
    wire free = enabled & ~task_halt & ~stop_seen & ~restart;
    wire dma_done = dma_busy_reg & mem_ack_i;
    wire tx_room = txa_reg < max_reg;
    wire rx_room = rxa_reg < max_reg;
    assign dma_adr = ptr_reg + 32'(rd_reg ? txa_reg : rxa_reg);
    wire stretch_next = enabled & ((st_next == ST_TXWAIT) | (st_next == ST_TXLOAD)
                      | (st_next == ST_RXWAIT) | (st_next == ST_RXSTORE));

    // Open-drain: only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = hold_reg;
    assign sda_oe_o = sda_reg;
    assign lowpower_o = (st_reg == ST_IDLE);
    assign mem_o = '{req: dma_busy_reg, we: dma_we_reg, addr: dma_adr_reg,
                     wdata: dma_wd_reg};

    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        rd_next = rd_reg;
        ptr_next = ptr_reg;
        max_next = max_reg;
        txa_next = txa_reg;
        rxa_next = rxa_reg;
        sda_next = sda_reg;
        nack_next = nack_reg;
        ev_set = '0;
        clr_tx = 1'b0;
        clr_rx = 1'b0;
        dma_go = 1'b0;
        if (!enabled) begin
            st_next = ST_IDLE;
            sda_next = 1'b0;
        end else if (task_halt) begin
            st_next = ST_HALT;
            sda_next = 1'b0;
        end else if (stop_seen) begin
            sda_next = 1'b0;
            st_next = (st_reg == ST_ADDR) ? ST_IDLE : ST_HALT;
        end else if (restart) begin
            st_next = ST_ADDR;
            cnt_next = '0;
            sda_next = 1'b0;
        end else begin
            case (st_reg)
                ST_ADDR: begin
                    if (ln.rise) begin
                        sh_next = {sh_reg[6:0], ln.sda};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (ln.fall && cnt_reg == BYTE_BITS) begin
                        if (addr_hit) begin
                            st_next = ST_AACK;
                            sda_next = 1'b1;
                            rd_next = sh_reg[0];
                            ev_set[EV_READ] = sh_reg[0];
                            ev_set[EV_WRITE] = ~sh_reg[0];
                        end else begin
                            st_next = ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    if (ln.fall) begin
                        sda_next = 1'b0;
                        st_next = rd_reg ? ST_TXWAIT : ST_RXWAIT;
                    end
                end
                ST_TXWAIT: begin
                    if (prep_tx_reg) begin
                        clr_tx = 1'b1;
                        ev_set[EV_TXB] = 1'b1;
                        ptr_next = txp_reg;
                        max_next = txm_reg;
                        txa_next = '0;
                        st_next = ST_TXLOAD;
                    end
                end
                ST_TXLOAD: begin
                    if (!tx_room) begin
                        sh_next = orc_reg;
                        ev_set[EV_ERR] = 1'b1;
                        cnt_next = '0;
                        sda_next = ~orc_reg[7];
                        st_next = ST_TXBITS;
                    end else if (dma_done) begin
                        sh_next = mem_rdata_i;
                        txa_next = txa_reg + 1'b1;
                        cnt_next = '0;
                        sda_next = ~mem_rdata_i[7];
                        st_next = ST_TXBITS;
                    end else if (!dma_busy_reg) begin
                        dma_go = 1'b1;
                    end
                end
                ST_TXBITS: begin
                    if (ln.fall) begin
                        cnt_next = cnt_reg + 4'h1;
                        if (cnt_reg == LAST_BIT) begin
                            sda_next = 1'b0;
                            st_next = ST_TXACK;
                        end else begin
                            sh_next = {sh_reg[6:0], 1'b0};
                            sda_next = ~sh_reg[6];
                        end
                    end
                end
                ST_TXACK: begin
                    if (ln.rise) begin
                        nack_next = ln.sda;
                    end else if (ln.fall) begin
                        st_next = nack_reg ? ST_TXEND : ST_TXLOAD;
                    end
                end
                ST_RXWAIT: begin
                    if (prep_rx_reg) begin
                        clr_rx = 1'b1;
                        ev_set[EV_RXB] = 1'b1;
                        ptr_next = rxp_reg;
                        max_next = rxm_reg;
                        rxa_next = '0;
                        cnt_next = '0;
                        st_next = ST_RXBITS;
                    end
                end
                ST_RXBITS: begin
                    if (ln.rise) begin
                        sh_next = {sh_reg[6:0], ln.sda};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (ln.fall && cnt_reg == BYTE_BITS) begin
                        st_next = ST_RXSTORE;
                    end
                end
                ST_RXSTORE: begin
                    if (!rx_room) begin
                        ev_set[EV_ERR] = 1'b1;
                        sda_next = 1'b0;
                        st_next = ST_RXACK;
                    end else if (dma_done) begin
                        rxa_next = rxa_reg + 1'b1;
                        sda_next = 1'b1;
                        st_next = ST_RXACK;
                    end else if (!dma_busy_reg) begin
                        dma_go = 1'b1;
                    end
                end
                ST_RXACK: begin
                    if (ln.fall) begin
                        sda_next = 1'b0;
                        cnt_next = '0;
                        st_next = ST_RXBITS;
                    end
                end
                ST_HALT: begin
                    sda_next = 1'b0;
                    // Buffers stay owned by the DMA until the last access ends
                    if (!dma_busy_reg) begin
                        ev_set[EV_STOP] = 1'b1;
                        clr_tx = rd_reg;
                        clr_rx = ~rd_reg;
                        st_next = ST_IDLE;
                    end
                end
                default: begin
                    st_next = st_reg;
                end
            endcase
        end
    end

    // Only reset and software writes touch settings; nothing else changes them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_reg <= EN_RST;
            cfg_reg <= CFG_RST;
            adr0_reg <= LISTEN_RST;
            adr1_reg <= LISTEN_RST;
            orc_reg <= FILL_RST;
            txp_reg <= '0;
            rxp_reg <= '0;
            txm_reg <= '0;
            rxm_reg <= '0;
        end else if (wr_now) begin
            if (adr_i == ADR_ENABLE) en_reg <= merged[EN_W-1:0];
            if (adr_i == ADR_CONFIG) cfg_reg <= merged[CFG_W-1:0];
            if (adr_i == ADR_LISTEN0) adr0_reg <= merged[6:0];
            if (adr_i == ADR_LISTEN1) adr1_reg <= merged[6:0];
            if (adr_i == ADR_FILL) orc_reg <= merged[7:0];
            if (adr_i == ADR_TX_PTR) txp_reg <= merged;
            if (adr_i == ADR_RX_PTR) rxp_reg <= merged;
            if (adr_i == ADR_TX_MAX) txm_reg <= merged[CNT_W-1:0];
            if (adr_i == ADR_RX_MAX) rxm_reg <= merged[CNT_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdat_reg <= '0;
        end else begin
            ack_reg <= rd_cap;
            if (rd_cap) rdat_reg <= rd_mux;
        end
    end

    // Set wins over clear for every flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_reg <= '0;
            prep_tx_reg <= 1'b0;
            prep_rx_reg <= 1'b0;
        end else begin
            ev_reg <= (ev_reg & ~ev_clr) | ev_set;
            prep_tx_reg <= task_ptx | (prep_tx_reg & ~clr_tx);
            prep_rx_reg <= task_prx | (prep_rx_reg & ~clr_rx);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dma_busy_reg <= 1'b0;
            dma_we_reg <= 1'b0;
            dma_adr_reg <= '0;
            dma_wd_reg <= '0;
        end else if (dma_go) begin
            dma_busy_reg <= 1'b1;
            dma_we_reg <= ~rd_reg;
            dma_adr_reg <= dma_adr;
            dma_wd_reg <= sh_reg;
        end else if (mem_ack_i) begin
            dma_busy_reg <= 1'b0;
        end
    end

    // Stretch is registered, so it lands a few clocks after SCL falls
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= ST_IDLE;
            cnt_reg <= '0;
            sh_reg <= '0;
            rd_reg <= 1'b0;
            ptr_reg <= '0;
            max_reg <= '0;
            txa_reg <= '0;
            rxa_reg <= '0;
            sda_reg <= 1'b0;
            nack_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            rd_reg <= rd_next;
            ptr_reg <= ptr_next;
            max_reg <= max_next;
            txa_reg <= txa_next;
            rxa_reg <= rxa_next;
            sda_reg <= sda_next;
            nack_reg <= nack_next;
            hold_reg <= stretch_next;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_tx_grant;
        st_reg == ST_TXWAIT && prep_tx_reg && free && !task_ptx;
    endsequence
    sequence s_rx_grant;
        st_reg == ST_RXWAIT && prep_rx_reg && free && !task_prx;
    endsequence
    sequence s_addr_done;
        st_reg == ST_ADDR && free && ln.fall && cnt_reg == BYTE_BITS;
    endsequence

    chk_tx_prep_set: assert property (task_ptx |=> prep_tx_reg)
        else $error("transmit flag not set by task");
    chk_tx_unprep: assert property (s_tx_grant |=> !prep_tx_reg && st_reg == ST_TXLOAD
        && ev_reg[EV_TXB])
        else $error("transmit entry wrong");
    chk_rx_prep_set: assert property (task_prx |=> prep_rx_reg)
        else $error("receive flag not set by task");
    chk_rx_unprep: assert property (s_rx_grant |=> !prep_rx_reg && st_reg == ST_RXBITS
        && ev_reg[EV_RXB])
        else $error("receive entry wrong");
    chk_stretch_wait: assert property (st_reg == ST_TXWAIT && !prep_tx_reg && free
        |=> scl_oe_o && st_reg == ST_TXWAIT)
        else $error("no stretch while unprepared");
    chk_disabled_quiet: assert property (!enabled ##1 !enabled |-> !scl_oe_o && !sda_oe_o
        && st_reg == ST_IDLE)
        else $error("disabled slave drives bus");
    chk_addr_match: assert property (s_addr_done |=> (sda_oe_o == $past(addr_hit))
        && (st_reg == ST_AACK) == $past(addr_hit))
        else $error("address acknowledge wrong");
    chk_halt_dma: assert property (ev_set[EV_STOP] |-> !dma_busy_reg ##1 st_reg == ST_IDLE)
        else $error("halted before DMA finished");
    chk_overread_fill: assert property (st_reg == ST_TXLOAD && free && !tx_room
        |=> sh_reg == orc_reg && ev_reg[EV_ERR])
        else $error("fill byte not sent");
    chk_overrecv_nack: assert property (st_reg == ST_RXSTORE && free && !rx_room
        |=> st_reg == ST_RXACK && !sda_oe_o && ev_reg[EV_ERR])
        else $error("extra byte not refused");
    chk_stop_state: assert property (enabled && !task_halt && stop_seen
        && st_reg != ST_ADDR |=> st_reg == ST_HALT)
        else $error("stop not followed");
    chk_idle_wait: assert property (st_reg == ST_IDLE && free && !ln.start
        |=> lowpower_o)
        else $error("left low power unaddressed");
endmodule // tws_top
`default_nettype wire

/* File: sim/tws_master.sv */
`timescale 1ns/100ps
`default_nettype none
module tws_master (
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_oe_o,
    output logic sda_oe_o
);
    // Half period of the 320 ns bus clock
    localparam time HALF = 160;
    // Only master on the bus, no arbitration needed; the slave may still stretch the bus clock
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
    end
    // Data moves only while clock is low, a quarter period after the fall
    task automatic clk_bit(input logic b, output logic r);
        #(HALF / 2) sda_oe_o = !b;
        #(HALF / 2) scl_oe_o = 1'b0;
        wait (scl_i === 1'b1);
        #HALF r = sda_i;
        scl_oe_o = 1'b1;
    endtask
    // Serves as start and as repeated start
    task automatic start();
        #(HALF / 2) sda_oe_o = 1'b0;
        #(HALF / 2) scl_oe_o = 1'b0;
        wait (scl_i === 1'b1);
        #HALF sda_oe_o = 1'b1;
        #HALF scl_oe_o = 1'b1;
    endtask
    task automatic stop();
        #(HALF / 2) sda_oe_o = 1'b1;
        #(HALF / 2) scl_oe_o = 1'b0;
        wait (scl_i === 1'b1);
        #HALF sda_oe_o = 1'b0;
        #HALF;
    endtask
    task automatic byte_wr(input logic [7:0] d, output logic nak);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], r);
        end
        clk_bit(1'b1, nak);
    endtask
    task automatic byte_rd(input logic nak, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, d[i]);
        end
        clk_bit(nak, r);
    endtask
endmodule // tws_master
`default_nettype wire

/* File: sim/test_tws_top.sv */
`timescale 1ns/100ps
`default_nettype none
module test_tws_top;
    import tws_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o, scl_oe_o, sda_oe_o, m_scl_oe, m_sda_oe, lowpower_o, a;
    logic mem_ack_i = 1'b0;
    logic [7:0] mem_rdata_i = 8'h00;
    logic [7:0] d8;
    logic [31:0] d;
    logic [7:0] ram [0:255];
    tws_dma_t mem_o;
    int fail_count = 0;
    int n_tests = 0;
    // Open drain: any party enabling pulls the line low
    wire scl = !(m_scl_oe | scl_oe_o);
    wire sda = !(m_sda_oe | sda_oe_o);
    always #20 clk_i = !clk_i;
    tws_top i_tws_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe_o), .sda_i(sda),
        .sda_o(), .sda_oe_o(sda_oe_o), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i),
        .mem_ack_i(mem_ack_i), .lowpower_o(lowpower_o));
    tws_master i_tws_master (.scl_i(scl), .sda_i(sda), .scl_oe_o(m_scl_oe),
        .sda_oe_o(m_sda_oe));
    // Memory answers one cycle late; read pattern is address xor 0x3c
    always @(posedge clk_i) begin
        mem_ack_i <= 1'b0;
        if (mem_o.req && !mem_ack_i) begin
            mem_ack_i <= 1'b1;
            mem_rdata_i <= mem_o.addr[7:0] ^ 8'h3c;
            if (mem_o.we) begin
                ram[mem_o.addr[7:0]] <= mem_o.wdata;
            end
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Hold the request until ack is seen, release at that same edge
    task automatic wb_cycle(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= ad;
        dat_i <= wd;
        // Ack and read data are taken at the rising edge, release follows at once
        do @(posedge clk_i); while (ack_o !== 1'b1);
        d = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #1_000_000;
        fail_count++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(lowpower_o, 1'b1);
        i_tws_master.start();
        i_tws_master.byte_wr({7'h42, 1'b0}, a);
        i_tws_master.stop();
        chk(a, 1'b1);
        // All settings before enabling; none touched while enabled
        wb_cycle(1'b1, ADR_LISTEN0, 32'h42);
        wb_cycle(1'b1, ADR_RX_PTR, 32'h180);
        wb_cycle(1'b1, ADR_RX_MAX, 32'h2);
        wb_cycle(1'b1, ADR_TX_PTR, 32'h200);
        wb_cycle(1'b1, ADR_TX_MAX, 32'h1);
        wb_cycle(1'b1, ADR_FILL, 32'h5e);
        wb_cycle(1'b1, ADR_ENABLE, {28'h0, EN_ON});
        i_tws_master.start();
        i_tws_master.byte_wr({7'h42, 1'b0}, a);
        chk(a, 1'b0);
        fork
            i_tws_master.byte_wr(8'ha5, a);
            begin
                repeat (40) @(posedge clk_i);
                chk(scl_oe_o, 1'b1);
                chk(lowpower_o, 1'b0);
                wb_cycle(1'b1, ADR_TASK, 32'h1 << TSK_PRX);
            end
        join
        chk(a, 1'b0);
        wb_cycle(1'b0, ADR_TASK, 32'h0);
        chk(d, 32'h0);
        i_tws_master.byte_wr(8'h5a, a);
        chk(a, 1'b0);
        i_tws_master.byte_wr(8'hc3, a);
        chk(a, 1'b1);
        i_tws_master.stop();
        repeat (10) @(posedge clk_i);
        wb_cycle(1'b0, ADR_EVENT, 32'h0);
        chk(d[EV_W-1:0], 6'h33);
        chk({ram[8'h80], ram[8'h81]}, 16'ha55a);
        wb_cycle(1'b0, ADR_RX_AMT, 32'h0);
        chk(d, 32'h2);
        wb_cycle(1'b1, ADR_EVENT, 32'h3f);
        i_tws_master.start();
        i_tws_master.byte_wr({7'h43, 1'b0}, a);
        chk(a, 1'b1);
        i_tws_master.stop();
        wb_cycle(1'b0, ADR_EVENT, 32'h0);
        chk(d[EV_WRITE], 1'b0);
        wb_cycle(1'b1, ADR_TASK, (32'h1 << TSK_PTX) | (32'h1 << TSK_PRX));
        i_tws_master.start();
        i_tws_master.byte_wr({7'h42, 1'b1}, a);
        chk(a, 1'b0);
        i_tws_master.byte_rd(1'b0, d8);
        chk(d8, 8'h3c);
        i_tws_master.byte_rd(1'b1, d8);
        chk(d8, 8'h5e);
        i_tws_master.start();
        i_tws_master.byte_wr({7'h42, 1'b0}, a);
        chk(a, 1'b0);
        i_tws_master.stop();
        repeat (10) @(posedge clk_i);
        wb_cycle(1'b0, ADR_EVENT, 32'h0);
        chk(d[EV_W-1:0], 6'h3f);
        chk(lowpower_o, 1'b1);
        wb_cycle(1'b1, ADR_EVENT, 32'h3f);
        // Flag was used up by the last read, so this one must stretch
        i_tws_master.start();
        i_tws_master.byte_wr({7'h42, 1'b1}, a);
        fork
            i_tws_master.byte_rd(1'b1, d8);
            begin
                repeat (40) @(posedge clk_i);
                chk(scl_oe_o, 1'b1);
                wb_cycle(1'b1, ADR_TASK, 32'h1 << TSK_PTX);
            end
        join
        chk(d8, 8'h3c);
        i_tws_master.stop();
        end_of_test();
    end
endmodule // test_tws_top
`default_nettype wire
